/* File: common/ipg_regs.vh */
// Purpose: Register offsets, fields, reset values and timing for the interrupt and pin block.
// Assumes: 8-bit control port, 10 MHz core clock.
// Notes:   Definitions only.
`ifndef IPG_REGS_VH
`define IPG_REGS_VH
`define IPG_ADDR_IRQ1_CTRL   8'h30
`define IPG_ADDR_IRQ2_CTRL   8'h31
`define IPG_ADDR_RSVD_A      8'h32
`define IPG_ADDR_RSVD_B      8'h33
`define IPG_ADDR_PIN_CTRL    8'h34
`define IPG_ADDR_STICKY1     8'h2a
`define IPG_ADDR_STICKY2     8'h2c
`define IPG_BIT_OC_EN        3
`define IPG_BIT_TRAIN        0
`define IPG_BIT_PIN_IN       1
`define IPG_BIT_PIN_OUT      0
`define IPG_BIT_STICKY       7
`define IPG_FUNC_HI          5
`define IPG_FUNC_LO          2
`define IPG_RST_BYTE         8'h00
`define IPG_RST_FUNC         4'h0
`define IPG_FN_DISABLED      4'h0
`define IPG_FN_SEC_IN        4'h1
`define IPG_FN_GP_IN         4'h2
`define IPG_FN_GP_OUT        4'h3
`define IPG_FN_DIVIDED_CLOCK_OUTPUT        4'h4
`define IPG_FN_IRQ1          4'h5
`define IPG_FN_IRQ2          4'h6
`define IPG_FN_IRQ2_ALT      4'h7
`define IPG_FN_SEC_BCLK      4'h8
`define IPG_FN_SEC_WCLK      4'h9
`define IPG_FN_ZERO          4'ha
`define IPG_FN_DOUT          4'he
`define IPG_PULSE_NS         2000000
`define IPG_CLK_NS           100
// One 2 ms phase in 100 ns core clock cycles, sized to the phase counter.
`define IPG_PULSE_CYC        15'h4e20
`define IPG_CNT_W            15
`endif

/* File: src/ipg_pulse_gen.v */
// Purpose: Pulse generator for one interrupt line: single 2 ms pulse or a train.
// Assumes: Event and stop inputs are one-cycle pulses on the core clock.
// Notes:   High and low phases both last PULSE_CYC cycles.
`timescale 1ns/1ns
`include "ipg_regs.vh"
module ipg_pulse_gen #(
  parameter [`IPG_CNT_W-1:0] PULSE_CYC = `IPG_PULSE_CYC
) (
  input  wire clk_in,
  input  wire rst_in,
  input  wire event_in,
  input  wire train_in,
  input  wire stop_in,
  output reg  irq_out
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_HIGH = 2'h1;
  localparam [1:0] ST_LOW  = 2'h2;
  reg [1:0]            state;
  reg [`IPG_CNT_W-1:0] count;
  reg                  stop_held;
  wire                 last = (count == PULSE_CYC - 1'b1);

  // In the low phase, a stop arriving with a new event lets the event win, so it is not lost.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state   <= ST_IDLE;
      count     <= {`IPG_CNT_W{1'b0}};
      irq_out   <= 1'b0;
      stop_held <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          count <= {`IPG_CNT_W{1'b0}};
          if (event_in) begin
            state   <= ST_HIGH;
            irq_out <= 1'b1;
          end
        end
        ST_HIGH: begin
          count <= last ? {`IPG_CNT_W{1'b0}} : count + 1'b1;
          // The stop strobe lasts one cycle, so a read mid-pulse is held until the pulse ends.
          if (stop_in) begin
            stop_held <= 1'b1;
          end
          if (last) begin
            irq_out   <= 1'b0;
            stop_held <= 1'b0;
            state     <= (train_in && !stop_in && !stop_held) ? ST_LOW : ST_IDLE;
          end
        end
        ST_LOW: begin
          count <= last ? {`IPG_CNT_W{1'b0}} : count + 1'b1;
          if (stop_in && !event_in) begin
            state <= ST_IDLE;
          end else if (last) begin
            state   <= ST_HIGH;
            irq_out <= 1'b1;
          end
        end
        default: begin
          state     <= ST_IDLE;
          irq_out   <= 1'b0;
          stop_held <= 1'b0;
        end
      endcase
    end
  end
endmodule // ipg_pulse_gen

/* File: src/ipg_top.v */
// Purpose: Interrupt line pulse control and general purpose pin function mux.
// Assumes: Control port gives byte writes and reads with a one-cycle read strobe.
// Notes:   Over-current detector and serial data mux sit outside this block.
//
// Overview of operation
// - Line one over-current enable gates over-current events onto line one.
// - Line one train bit clear gives one 2 ms high pulse per event.
// - Line one train bit set repeats 2 ms pulses until a sticky read.
// - Line two over-current enable gates over-current events onto line two.
// - Line two train bit clear gives one 2 ms high pulse per event.
// - Line two train bit set repeats 2 ms pulses until a sticky read.
// - Code 0000 disables the pin; 0001 routes pin input to secondary use.
// - Code 0010 samples pin into status; 0011 drives output value bit.
// - Codes 0100, 0101, 0110/0111 drive clock output, line one, line two.
// - Code 1001 drives secondary word clock; 1000 drives secondary bit clock.
// - Code 1010 drives zero; 1110 drives serial data; others reserved.
// - Read-only bit one reflects the pin state in input mode.
// - Bit zero sets output level in output mode, reset zero.
// - Sticky over-current flag latches and clears when its register is read.
// - Sticky overflow flag latches and clears when its register is read.
`timescale 1ns/1ns
`include "ipg_regs.vh"
module ipg_top (
  input  wire       ref_clk_in,
  input  wire       rst_in,
  input  wire [7:0] reg_addr_in,
  input  wire [7:0] reg_wdata_in,
  input  wire       reg_write_in,
  input  wire       reg_read_in,
  output reg  [7:0] reg_rdata_out,
  input  wire       overcurrent_in,
  input  wire       dac_overflow_in,
  input  wire       pin_in,
  output reg        pin_out,
  output reg        pin_oe_out,
  output reg        sec_in_out,
  input  wire       divided_clock_output_in,
  input  wire       sec_bclk_in,
  input  wire       sec_wclk_in,
  input  wire       dout_in,
  output reg        irq_line_one_out,
  output reg        irq_line_two_out
);
  reg  [7:0] irq_one_ctrl;
  reg  [7:0] irq_two_ctrl;
  reg  [7:0] rsvd_a;
  reg  [7:0] rsvd_b;
  reg  [3:0] pin_func;
  reg        pin_level;
  reg        pin_sample;
  reg        sticky_oc;
  reg        sticky_ovf;
  reg        oc_prev;
  reg  [7:0] next_rdata;
  reg        next_pin;
  reg        next_oe;
  localparam NUM_LINES = 2;
  wire       line_one;
  wire       line_two;
  wire [1:0] line_en;
  wire [1:0] line_train;
  wire [1:0] line_irq;
  wire       oc_rise   = overcurrent_in & ~oc_prev;
  wire       rd_st1;
  wire       rd_st2;
  wire       stop_train;
  genvar     gi;

  // Shared address compare for writes, used for every register.
  function wr_hit;
    input [7:0] addr;
    input [7:0] target;
    input       wr;
    begin
      wr_hit = wr && (addr == target);
    end
  endfunction

  // Shared address compare for reads; a sticky read has side effects, so it must be exact.
  function rd_hit;
    input [7:0] addr;
    input [7:0] target;
    input       rd;
    begin
      rd_hit = rd && (addr == target);
    end
  endfunction

  // A read of either sticky register clears its flag and ends any running train.
  assign rd_st1     = rd_hit(reg_addr_in, `IPG_ADDR_STICKY1, reg_read_in);
  assign rd_st2     = rd_hit(reg_addr_in, `IPG_ADDR_STICKY2, reg_read_in);
  assign stop_train = rd_st1 | rd_st2;

  // Register writes; control registers store only their documented writable bits, reserved registers the whole byte.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_one_ctrl <= `IPG_RST_BYTE;
      irq_two_ctrl <= `IPG_RST_BYTE;
      rsvd_a       <= `IPG_RST_BYTE;
      rsvd_b       <= `IPG_RST_BYTE;
      pin_func     <= `IPG_RST_FUNC;
      pin_level    <= 1'b0;
    end else begin
      if (wr_hit(reg_addr_in, `IPG_ADDR_IRQ1_CTRL, reg_write_in)) begin
        irq_one_ctrl[`IPG_BIT_OC_EN] <= reg_wdata_in[`IPG_BIT_OC_EN];
        irq_one_ctrl[`IPG_BIT_TRAIN] <= reg_wdata_in[`IPG_BIT_TRAIN];
      end
      if (wr_hit(reg_addr_in, `IPG_ADDR_IRQ2_CTRL, reg_write_in)) begin
        irq_two_ctrl[`IPG_BIT_OC_EN] <= reg_wdata_in[`IPG_BIT_OC_EN];
        irq_two_ctrl[`IPG_BIT_TRAIN] <= reg_wdata_in[`IPG_BIT_TRAIN];
      end
      // Stored as written; software is expected to keep these at zero.
      if (wr_hit(reg_addr_in, `IPG_ADDR_RSVD_A, reg_write_in)) begin
        rsvd_a <= reg_wdata_in;
      end
      if (wr_hit(reg_addr_in, `IPG_ADDR_RSVD_B, reg_write_in)) begin
        rsvd_b <= reg_wdata_in;
      end
      if (wr_hit(reg_addr_in, `IPG_ADDR_PIN_CTRL, reg_write_in)) begin
        pin_func  <= reg_wdata_in[`IPG_FUNC_HI:`IPG_FUNC_LO];
        pin_level <= reg_wdata_in[`IPG_BIT_PIN_OUT];
      end
    end
  end

  // Sticky flags: a new event in the read cycle wins over the clear, so none is lost.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sticky_oc  <= 1'b0;
      sticky_ovf <= 1'b0;
      oc_prev    <= 1'b0;
      pin_sample <= 1'b0;
    end else begin
      oc_prev    <= overcurrent_in;
      sticky_oc  <= overcurrent_in | (sticky_oc & ~rd_st2);
      sticky_ovf <= dac_overflow_in | (sticky_ovf & ~rd_st1);
      pin_sample <= pin_in;
    end
  end

  // Each line fires on the rising edge of over-current when its enable is set.
  // The lines differ only in their control register; both share the stop strobe.
  assign line_en    = {irq_two_ctrl[`IPG_BIT_OC_EN], irq_one_ctrl[`IPG_BIT_OC_EN]};
  assign line_train = {irq_two_ctrl[`IPG_BIT_TRAIN], irq_one_ctrl[`IPG_BIT_TRAIN]};
  assign line_one   = line_irq[0];
  assign line_two   = line_irq[1];

  generate
    for (gi = 0; gi < NUM_LINES; gi = gi + 1) begin : g_line
      ipg_pulse_gen u_gen (
        .clk_in   (ref_clk_in),
        .rst_in   (rst_in),
        .event_in (oc_rise & line_en[gi]),
        .train_in (line_train[gi]),
        .stop_in  (stop_train),
        .irq_out  (line_irq[gi])
      );
    end
  endgenerate

  // Pin function mux; reserved codes leave the pin undriven as a safe choice.
  always @* begin
    next_pin = 1'b0;
    next_oe  = 1'b1;
    case (pin_func)
      `IPG_FN_DISABLED: next_oe = 1'b0;
      `IPG_FN_SEC_IN:   next_oe = 1'b0;
      `IPG_FN_GP_IN:    next_oe = 1'b0;
      `IPG_FN_GP_OUT:   next_pin = pin_level;
      `IPG_FN_DIVIDED_CLOCK_OUTPUT:   next_pin = divided_clock_output_in;
      `IPG_FN_IRQ1:     next_pin = line_one;
      `IPG_FN_IRQ2:     next_pin = line_two;
      `IPG_FN_IRQ2_ALT: next_pin = line_two;
      `IPG_FN_SEC_BCLK: next_pin = sec_bclk_in;
      `IPG_FN_SEC_WCLK: next_pin = sec_wclk_in;
      `IPG_FN_ZERO:     next_pin = 1'b0;
      `IPG_FN_DOUT:     next_pin = dout_in;
      default:          next_oe = 1'b0;
    endcase
  end

  // Read data mux; unmapped addresses read as zero.
  always @* begin
    next_rdata = `IPG_RST_BYTE;
    case (reg_addr_in)
      `IPG_ADDR_IRQ1_CTRL: next_rdata = irq_one_ctrl;
      `IPG_ADDR_IRQ2_CTRL: next_rdata = irq_two_ctrl;
      `IPG_ADDR_RSVD_A:    next_rdata = rsvd_a;
      `IPG_ADDR_RSVD_B:    next_rdata = rsvd_b;
      `IPG_ADDR_PIN_CTRL: begin
        next_rdata[`IPG_FUNC_HI:`IPG_FUNC_LO] = pin_func;
        next_rdata[`IPG_BIT_PIN_IN]  = pin_sample;
        next_rdata[`IPG_BIT_PIN_OUT] = pin_level;
      end
      `IPG_ADDR_STICKY1:   next_rdata[`IPG_BIT_STICKY] = sticky_ovf;
      `IPG_ADDR_STICKY2:   next_rdata[`IPG_BIT_STICKY] = sticky_oc;
      default:             next_rdata = `IPG_RST_BYTE;
    endcase
  end

  // Registered outputs; the pin path adds one cycle of delay to every source.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out    <= `IPG_RST_BYTE;
      pin_out          <= 1'b0;
      pin_oe_out       <= 1'b0;
      sec_in_out       <= 1'b0;
      irq_line_one_out <= 1'b0;
      irq_line_two_out <= 1'b0;
    end else begin
      if (reg_read_in) begin
        reg_rdata_out <= next_rdata;
      end
      pin_out          <= next_pin;
      pin_oe_out       <= next_oe;
      sec_in_out       <= (pin_func == `IPG_FN_SEC_IN) ? pin_in : 1'b0;
      irq_line_one_out <= line_one;
      irq_line_two_out <= line_two;
    end
  end
endmodule // ipg_top

/* File: testbench/ipg_top_props.sv */
// Purpose: Port checker for the interrupt and pin block.
// Assumes: 10 MHz clock, so a 2 ms pulse is 20000 cycles.
// Notes:   Written control bits are shadowed from the write port.
`timescale 1ns/1ns
module ipg_top_props (
  input wire       ref_clk_in,
  input wire       rst_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire       reg_write_in,
  input wire       pin_out,
  input wire       pin_oe_out,
  input wire       divided_clock_output_in,
  input wire       irq_line_one_out,
  input wire       irq_line_two_out
);
  localparam logic [15:0] P = 16'h4e20;
  logic [4:0]  pc;
  logic        e1, e2;
  logic [15:0] n1, n2;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Shadow registers; the counters time each high phase so short pulses are caught.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      {pc, e1, e2, n1, n2} <= '0;
    end else begin
      if (reg_write_in && reg_addr_in == 8'h34) pc <= {reg_wdata_in[5:2], reg_wdata_in[0]};
      if (reg_write_in && reg_addr_in == 8'h30) e1 <= reg_wdata_in[3];
      if (reg_write_in && reg_addr_in == 8'h31) e2 <= reg_wdata_in[3];
      n1 <= irq_line_one_out ? n1 + 16'h0001 : 16'h0000;
      n2 <= irq_line_two_out ? n2 + 16'h0001 : 16'h0000;
    end
  end
  off_idle_a: assert property ($past(pc[4:1]) == 4'h0 |-> !pin_oe_out)
    else $error("pin driven while off");
  gp_out_a: assert property ($past(pc[4:1]) == 4'h3 |-> pin_oe_out && pin_out == $past(pc[0]))
    else $error("output value wrong");
  clk_out_a: assert property ($past(pc[4:1]) == 4'h4 |->
    pin_oe_out && pin_out == $past(divided_clock_output_in))
    else $error("clock not on pin");
  zero_out_a: assert property ($past(pc[4:1]) == 4'ha |-> pin_oe_out && !pin_out)
    else $error("pin not zero");
  en_one_a: assert property ($rose(irq_line_one_out) |-> $past(e1, 2))
    else $error("line one raised while off");
  en_two_a: assert property ($rose(irq_line_two_out) |-> $past(e2, 2))
    else $error("line two raised while off");
  pulse_one_a: assert property ($fell(irq_line_one_out) |-> n1 == P)
    else $error("line one pulse length");
  pulse_two_a: assert property ($fell(irq_line_two_out) |-> n2 == P)
    else $error("line two pulse length");
endmodule // ipg_top_props
bind ipg_top ipg_top_props i_ipg_top_props (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
  .pin_out(pin_out), .pin_oe_out(pin_oe_out), .divided_clock_output_in(divided_clock_output_in),
  .irq_line_one_out(irq_line_one_out), .irq_line_two_out(irq_line_two_out));

/* File: testbench/ipg_host_model.sv */
// Purpose: Far side of the pin and the clock sources.
// Assumes: Sources move on the falling edge only.
// Notes:   Pin level is seen only while the block leaves the pin free.
`timescale 1ns/1ns
module ipg_host_model (
  input  wire  clk_in,
  input  wire  rst_in,
  output logic clk_src_out,
  output logic bclk_out,
  output logic wclk_out,
  output logic dout_out,
  output logic pin_level_out
);
  logic [5:0] cnt;
  // Each clock source runs at its own rate and data runs at the word clock rate but another phase, so a wrong mux choice shows up.
  always @(negedge clk_in or posedge rst_in) begin
    if (rst_in) cnt <= 6'h00;
    else cnt <= cnt + 6'h01;
  end
  assign {pin_level_out, dout_out, wclk_out, bclk_out, clk_src_out} =
    {cnt[5], cnt[1] ^ cnt[2], cnt[2], cnt[1], cnt[0]};
endmodule // ipg_host_model

/* File: testbench/ipg_top_tb.sv */
// Purpose: Self-checking bench for the interrupt and pin block.
// Assumes: 10 MHz clock; 2 ms pulses of 20000 cycles.
// Notes:   One event pulses both lines; line two runs a train.
`timescale 1ns/1ns
module ipg_top_tb;
  localparam logic [15:0] P = 16'h4e20;
  logic clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, oc = 1'b0, ovf = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, got;
  logic pin_o, pin_oe, sec_in, irq1, irq2, s_clk, s_bclk, s_wclk, s_dout, host_pin;
  wire  pin = pin_oe ? pin_o : host_pin;
  int   errors = 0, checks_done = 0, ones = 0, n;
  ipg_top i_ipg_top (.ref_clk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_write_in(wr_en), .reg_read_in(rd_en), .reg_rdata_out(rdata), .overcurrent_in(oc),
    .dac_overflow_in(ovf), .pin_in(pin), .pin_out(pin_o), .pin_oe_out(pin_oe),
    .sec_in_out(sec_in), .divided_clock_output_in(s_clk), .sec_bclk_in(s_bclk),
    .sec_wclk_in(s_wclk), .dout_in(s_dout), .irq_line_one_out(irq1), .irq_line_two_out(irq2));
  ipg_host_model i_ipg_host_model (.clk_in(clk), .rst_in(rst), .clk_src_out(s_clk),
    .bclk_out(s_bclk), .wclk_out(s_wclk), .dout_out(s_dout), .pin_level_out(host_pin));
  // Free-running core clock.
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic cyc();
    @(posedge clk) #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // The strobe drops one edge before the next access, so no time step sets it twice.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    cyc();
    wr_en = 1'b0;
    cyc();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr = a;
    rd_en = 1'b1;
    cyc();
    rd_en = 1'b0;
    cyc();
    d = rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a, got);
    chk(got, e);
  endtask
  task automatic run(input logic lvl, input int lim, output int k);
    k = 0;
    while (irq2 === lvl && k < lim) begin
      cyc();
      k++;
      if (irq1 !== 1'b0) ones++;
    end
  endtask
  task automatic t_regs();
    rdc(8'h30, 8'h00);
    rdc(8'h31, 8'h00);
    rdc(8'h33, 8'h00);
    rd(8'h34, got);
    chk(got & 8'hfd, 8'h00);
    rdc(8'h40, 8'h00);
    wr(8'h30, 8'hff);
    rdc(8'h30, 8'h09);
    wr(8'h30, 8'h00);
  endtask
  task automatic t_pin();
    logic [1:0] ev;
    for (int i = 0; i < 16; i++) begin
      wr(8'h34, {2'b00, i[3:0], 1'b0, i[0]});
      case (i[3:0])
        4'h3: ev = 2'b11;
        4'h4: ev = {1'b1, s_clk};
        4'h5, 4'h6, 4'h7, 4'ha: ev = 2'b10;
        4'h8: ev = {1'b1, s_bclk};
        4'h9: ev = {1'b1, s_wclk};
        4'he: ev = {1'b1, s_dout};
        default: ev = 2'b00;
      endcase
      chk({pin_oe, pin_o & ev[1]}, ev);
      if (i == 1) chk(sec_in, pin);
    end
    wr(8'h34, 8'h0c);
    chk({pin_oe, pin_o}, 2'b10);
    wr(8'h34, 8'h08);
    for (int i = 0; i < 4; i++) begin
      repeat (20) cyc();
      ev[0] = pin;
      cyc();
      rd(8'h34, got);
      if (ev[0] === pin) chk(got, {6'h02, ev[0], 1'b0});
    end
  endtask
  task automatic event_in(input logic is_oc);
    if (is_oc) oc = 1'b1;
    else ovf = 1'b1;
    cyc();
    {oc, ovf} = 2'b00;
  endtask
  task automatic t_irq_off();
    event_in(1'b0);
    rdc(8'h2a, 8'h80);
    rdc(8'h2a, 8'h00);
    wr(8'h31, 8'h01);
    event_in(1'b1);
    run(1'b0, 100, n);
    chk(ones, 0);
    chk(n, 100);
    rdc(8'h2c, 8'h80);
    rdc(8'h2c, 8'h00);
  endtask
  task automatic t_irq_on();
    wr(8'h30, 8'h08);
    wr(8'h31, 8'h09);
    event_in(1'b1);
    run(1'b0, 10, n);
    chk(irq1, 1'b1);
    run(1'b1, 30000, n);
    chk(n, P);
    ones = 0;
    run(1'b0, 30000, n);
    chk(n, P);
    rdc(8'h2c, 8'h80);
    run(1'b1, 30000, n);
    chk(n, P - 16'h0002);
    run(1'b0, 20100, n);
    chk(n, 20100);
    chk(ones, 0);
  endtask
  task automatic end_sim();
    if (errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Cuts a hang short a little beyond the expected length of the run.
  initial begin
    #9500000;
    errors++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    cyc();
    t_regs();
    t_pin();
    t_irq_off();
    t_irq_on();
    end_sim();
  end
endmodule // ipg_top_tb
